// ---- hw/debug_step_return_control.v ----
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "dbg_step_defines.vh"
module debug_step_return_control (
	input  wire        ref_clk,
	input  wire        rstn,
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata_q,
	input  wire        cmd_valid,
	input  wire [7:0]  cmd_code,
	input  wire        xfer_done,
	input  wire        break_req,
	input  wire        break_match,
	input  wire [15:0] cpu_ip,
	input  wire        cpu_ige,
	input  wire        cpu_done,
	input  wire        wake_irq,
	output reg  [1:0]  status_q,
	output reg  [15:0] ip_load_q,
	output reg         ip_load_en_q,
	output reg         interrupt_global_enable_q,
	output reg         cpu_run_q,
	output reg         fetch_block_q,
	output reg         brk_suppress_q,
	output reg         timer_enable_q,
	output reg         sys_clk_en_q,
	output reg         stop_q,
	output reg  [7:0]  dump_byte_q,
	output reg         dump_word_pair_q,
	output reg  [7:0]  dump_word_q,
	output reg         urom_step_q
);
	localparam S_BG    = 3'd0;
	localparam S_IDLE  = 3'd1;
	localparam S_POP   = 3'd2;
	localparam S_STEP  = 3'd3;
	localparam S_PUSH  = 3'd4;
	localparam S_RET   = 3'd5;
	localparam S_DUMP  = 3'd6;

	reg        rst_s1_q;
	reg        rst_n_q;
	reg [2:0]  state_q;
	reg        ige_entry_q;
	reg        push_q;
	reg        pop_q;
	reg [15:0] push_data_q;
	reg [7:0]  debug_byte_buffer_q;
	reg        transfer_complete_flag_q;
	reg        dump_first_q;
	reg        dump_lo_q;
	reg [15:0] ret_addr_q;
	reg        xs1_q;
	reg        xs2_q;
	reg        xs3_q;
	wire [15:0] stack_top;
	wire [3:0]  stack_count;
	wire        xfer_pulse;
	wire        is_cmd;

	// Transfer strobe comes from the pin side, so it is synchronised.
	assign xfer_pulse = xs2_q & ~xs3_q;
	// Outside idle debug mode a command leaves stack and pointer alone.
	assign is_cmd     = cmd_valid && state_q == S_IDLE;

	function in_urom;
		input [15:0] a;
		begin
			in_urom = (a >= `UROM_BASE);
		end
	endfunction

	function cmd_hit;
		input [7:0] want;
		begin
			cmd_hit = is_cmd && cmd_code == want;
		end
	endfunction

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	step_stack u_stack (
		.clk       (ref_clk),
		.rst_n     (rst_n_q),
		.push      (push_q),
		.pop       (pop_q),
		.push_data (push_data_q),
		.top_data  (stack_top),
		.count_q   (stack_count)
	);

	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			xs1_q <= 1'b0;
			xs2_q <= 1'b0;
			xs3_q <= 1'b0;
		end else begin
			xs1_q <= xfer_done;
			xs2_q <= xs1_q;
			xs3_q <= xs2_q;
		end
	end

	// A register-forced stop ends on reset, on a control write with the stop bit clear, or on a wake event while the entry enable is set.
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q                   <= S_BG;
			status_q                  <= `ST_NONDEBUG;
			ige_entry_q               <= 1'b0;
			interrupt_global_enable_q <= 1'b0;
			push_q                    <= 1'b0;
			pop_q                     <= 1'b0;
			push_data_q               <= 16'h0000;
			ret_addr_q                <= 16'h0000;
			ip_load_q                 <= 16'h0000;
			ip_load_en_q              <= 1'b0;
			cpu_run_q                 <= 1'b1;
			fetch_block_q             <= 1'b0;
			brk_suppress_q            <= 1'b0;
			timer_enable_q            <= 1'b1;
			sys_clk_en_q              <= 1'b1;
			urom_step_q               <= 1'b0;
			dump_first_q              <= 1'b0;
			dump_lo_q                 <= 1'b0;
			dump_word_q               <= 8'h00;
			dump_word_pair_q          <= 1'b0;
			dump_byte_q               <= 8'h00;
		end else begin
			push_q       <= 1'b0;
			pop_q        <= 1'b0;
			ip_load_en_q <= 1'b0;
			if (cpu_run_q && !brk_suppress_q)
				brk_suppress_q <= 1'b0;
			case (state_q)
			S_BG: begin
				if (cpu_done)
					brk_suppress_q <= 1'b0;
				if (break_req || (break_match && !brk_suppress_q)) begin
					// Entry takes a stack slot for the return address.
					push_q         <= 1'b1;
					push_data_q    <= cpu_ip;
					ret_addr_q     <= cpu_ip;
					ige_entry_q    <= cpu_ige;
					cpu_run_q      <= 1'b0;
					timer_enable_q <= 1'b0;
					sys_clk_en_q   <= 1'b0;
					interrupt_global_enable_q <= 1'b0;
					status_q       <= `ST_IDLE;
					state_q        <= S_IDLE;
				end
			end
			S_IDLE: begin
				// Clock runs only while a command is in progress.
				sys_clk_en_q <= cmd_valid;
				if (cmd_hit(`CMD_TRACE)) begin
					status_q <= `ST_BUSY;
					pop_q    <= 1'b1;
					state_q  <= S_POP;
				end else if (cmd_hit(`CMD_RETURN)) begin
					status_q <= `ST_BUSY;
					pop_q    <= 1'b1;
					state_q  <= S_RET;
				end else if (cmd_hit(`CMD_DUMP)) begin
					status_q     <= `ST_BUSY;
					dump_first_q <= 1'b1;
					dump_lo_q    <= 1'b1;
					dump_word_q  <= 8'h00;
					state_q      <= S_DUMP;
				end
			end
			S_POP: begin
				sys_clk_en_q <= 1'b1;
				// The pop lands on this same edge, so the top is still valid.
				ret_addr_q   <= stack_top;
				ip_load_q    <= stack_top;
				ip_load_en_q <= 1'b1;
				// Entry enable restored so an interrupt may be taken.
				interrupt_global_enable_q <= ige_entry_q;
				// Data from utility ROM is not trusted during a step.
				urom_step_q   <= in_urom(stack_top);
				fetch_block_q <= 1'b0;
				cpu_run_q     <= 1'b1;
				state_q       <= S_STEP;
			end
			S_STEP: begin
				// Stepped writes to the enable are overridden.
				interrupt_global_enable_q <= ige_entry_q;
				if (cpu_done) begin
					cpu_run_q     <= 1'b0;
					fetch_block_q <= 1'b1;
					// Stop with enable set stays waiting for a wake event.
					if (!(stop_q && ige_entry_q && !wake_irq))
						state_q <= S_PUSH;
				end
			end
			S_PUSH: begin
				push_q      <= 1'b1;
				push_data_q <= cpu_ip;
				// The address register follows the entry now on the stack.
				ret_addr_q  <= cpu_ip;
				ip_load_q   <= `DEBUG_VECTOR;
				ip_load_en_q <= 1'b1;
				interrupt_global_enable_q <= 1'b0;
				urom_step_q <= 1'b0;
				status_q    <= `ST_IDLE;
				state_q     <= S_IDLE;
			end
			S_RET: begin
				ip_load_q      <= stack_top;
				ip_load_en_q   <= 1'b1;
				interrupt_global_enable_q <= ige_entry_q;
				cpu_run_q      <= 1'b1;
				fetch_block_q  <= 1'b0;
				brk_suppress_q <= 1'b1;
				timer_enable_q <= 1'b1;
				sys_clk_en_q   <= 1'b1;
				status_q       <= `ST_NONDEBUG;
				state_q        <= S_BG;
			end
			S_DUMP: begin
				sys_clk_en_q <= 1'b1;
				if (xfer_pulse && transfer_complete_flag_q) begin
					status_q    <= `ST_VALID;
					dump_byte_q <= dump_first_q ? `PERIPH_WORDS
						: debug_byte_buffer_q;
					dump_first_q <= 1'b0;
					if (!dump_first_q) begin
						dump_lo_q <= ~dump_lo_q;
						if (!dump_lo_q) begin
							if (dump_word_q == `DUMP_LAST_WORD) begin
								status_q <= `ST_IDLE;
								state_q  <= S_IDLE;
							end
							dump_word_q <= dump_word_q + 8'd1;
						end
					end
					dump_word_pair_q <= (dump_word_q >= `DUMP_PAIR_WORD);
				end
			end
			default: state_q <= S_BG;
			endcase
		end
	end

	// Software loads the buffer and sets the flag; a transfer during a dump clears it.
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			debug_byte_buffer_q      <= 8'h00;
			transfer_complete_flag_q <= 1'b0;
			stop_q                   <= 1'b0;
			rdata_q                  <= 16'h0000;
		end else begin
			if (wr && addr == `ADDR_BUF) begin
				debug_byte_buffer_q      <= wdata[7:0];
				transfer_complete_flag_q <= 1'b1;
			end else if (xfer_pulse && state_q == S_DUMP)
				transfer_complete_flag_q <= 1'b0;
			if (wr && addr == `ADDR_CTRL)
				stop_q <= wdata[`CTRL_STOPREQ_BIT];
			else if (wake_irq && ige_entry_q)
				stop_q <= 1'b0;
			rdata_q <= 16'h0000;
			if (rd) begin
				case (addr)
				`ADDR_CTRL:   rdata_q <= {14'h0000, transfer_complete_flag_q,
					stop_q};
				`ADDR_STATUS: rdata_q <= {dump_word_q, 1'b0, state_q,
					urom_step_q, stack_count == `STACK_DEPTH,
					status_q};
				`ADDR_BUF:    rdata_q <= {8'h00, debug_byte_buffer_q};
				`ADDR_IP:     rdata_q <= ret_addr_q;
				`ADDR_SP:     rdata_q <= {12'h000, stack_count};
				default:      rdata_q <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// ---- hw/step_stack.v ----
`timescale 1ns/1ps
`include "dbg_step_defines.vh"

// Circular return-address stack; a push when full drops the oldest entry.
module step_stack (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        push,
	input  wire        pop,
	input  wire [15:0] push_data,
	output wire [15:0] top_data,
	output reg  [3:0]  count_q
);
	reg [15:0] mem [0:`STACK_DEPTH-1];
	reg [2:0]  ptr_q;

	assign top_data = mem[ptr_q - 3'd1];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q   <= 3'd0;
			count_q <= 4'd0;
		end else if (push) begin
			ptr_q <= ptr_q + 3'd1;
			// Full stack keeps its count: oldest entry overwritten.
			if (count_q != `STACK_DEPTH)
				count_q <= count_q + 4'd1;
		end else if (pop && count_q != 4'd0) begin
			ptr_q   <= ptr_q - 3'd1;
			count_q <= count_q - 4'd1;
		end
	end

	always @(posedge clk) begin
		if (push)
			mem[ptr_q] <= push_data;
	end
endmodule

// ---- include/dbg_step_defines.vh ----
`ifndef DBG_STEP_DEFINES_VH
`define DBG_STEP_DEFINES_VH

`define ST_NONDEBUG       2'b00
`define ST_IDLE           2'b01
`define ST_BUSY           2'b10
`define ST_VALID          2'b11

`define CMD_TRACE         8'h26
`define CMD_RETURN        8'h27
`define CMD_DUMP          8'h2A

`define DEBUG_VECTOR      16'h8010
`define UROM_BASE         16'h8000
`define STACK_DEPTH       8
`define PERIPH_WORDS      8'hB4
`define DUMP_LAST_WORD    8'hD7
`define DUMP_PAIR_WORD    8'hB8

`define ADDR_CTRL         4'h0
`define ADDR_STATUS       4'h1
`define ADDR_BUF          4'h2
`define ADDR_IP           4'h3
`define ADDR_SP           4'h4
`define CTRL_STOPREQ_BIT  0
`define CTRL_TXC_BIT      1

`endif

// ---- tb/debug_host_model.sv ----
`timescale 1ns/1ps
`include "dbg_step_defines.vh"

// Offers one command and drops it once the engine has seen it.
module debug_host_model (
	input  wire logic       ref_clk,
	input  wire logic       go,
	input  wire logic [7:0] code,
	input  wire logic [1:0] status_q,
	output logic            cmd_valid,
	output logic [7:0]      cmd_code
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
	end
	// Leaving debug is always by return; ROM code is never stepped. The engine still steps into utility ROM and sets urom_step_q.
	// The top 32 bytes of data memory are left to the service code.
	always @(posedge ref_clk) begin
		if (go && !cmd_valid) begin
			cmd_valid <= 1'b1;
			cmd_code <= code;
		end else if (cmd_valid && status_q != `ST_IDLE) begin
			cmd_valid <= 1'b0;
			// A stale code must not look like a fresh request.
			cmd_code <= ~cmd_code;
		end
	end
endmodule

// ---- tb/debug_step_return_control_tb.sv ----
`timescale 1ns/1ps
`include "dbg_step_defines.vh"

module debug_step_return_control_tb;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] cpu_ip = 16'h0000;
	logic [15:0] rdata_q, ip_load_q, v;
	logic [7:0]  code = 8'h00;
	logic [7:0]  cmd_code, dump_byte_q, dump_word_q;
	logic [1:0]  status_q;
	logic        wr = 1'b0, rd = 1'b0, go = 1'b0, cmd_valid;
	logic        xfer_done = 1'b0, break_req = 1'b0, break_match = 1'b0;
	logic        cpu_ige = 1'b0, cpu_done = 1'b0, wake_irq = 1'b0;
	logic        ip_load_en_q, interrupt_global_enable_q, cpu_run_q;
	logic        fetch_block_q, brk_suppress_q, timer_enable_q;
	logic        sys_clk_en_q, stop_q, dump_word_pair_q, urom_step_q;
	int          num_errors = 0;
	int          tests_run = 0;
	int          i;

	always #2.5 ref_clk = ~ref_clk;

	debug_host_model host (.ref_clk(ref_clk), .go(go), .code(code),
		.status_q(status_q), .cmd_valid(cmd_valid), .cmd_code(cmd_code));

	debug_step_return_control uut (.ref_clk(ref_clk), .rstn(rstn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .xfer_done(xfer_done),
		.break_req(break_req), .break_match(break_match), .cpu_ip(cpu_ip),
		.cpu_ige(cpu_ige), .cpu_done(cpu_done), .wake_irq(wake_irq),
		.status_q(status_q), .ip_load_q(ip_load_q),
		.ip_load_en_q(ip_load_en_q),
		.interrupt_global_enable_q(interrupt_global_enable_q),
		.cpu_run_q(cpu_run_q), .fetch_block_q(fetch_block_q),
		.brk_suppress_q(brk_suppress_q), .timer_enable_q(timer_enable_q),
		.sys_clk_en_q(sys_clk_en_q), .stop_q(stop_q),
		.dump_byte_q(dump_byte_q), .dump_word_pair_q(dump_word_pair_q),
		.dump_word_q(dump_word_q), .urom_step_q(urom_step_q));

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata_q;
	endtask

	// One pin transfer; the synchroniser shows the byte three edges later.
	task automatic xfer;
		@(posedge ref_clk);
		xfer_done <= 1'b1;
		@(posedge ref_clk);
		xfer_done <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic issue(input logic [7:0] c);
		@(posedge ref_clk);
		go <= 1'b1;
		code <= c;
		@(posedge ref_clk);
		go <= 1'b0;
	endtask

	task automatic wait_st(input logic [1:0] s);
		int n;
		n = 0;
		while (status_q !== s && n < 50) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("status", 16'(status_q), 16'(s));
	endtask

	// Breaks in with the interrupt enable set at the given address.
	task automatic enter(input logic [15:0] ip);
		@(posedge ref_clk);
		cpu_ip <= ip;
		cpu_ige <= 1'b1;
		break_req <= 1'b1;
		wait_st(`ST_IDLE);
		@(posedge ref_clk);
		break_req <= 1'b0;
	endtask

	initial begin
		repeat (10000) @(posedge ref_clk);
		num_errors++;
		test_done();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("rst", 16'({status_q, cpu_run_q, timer_enable_q}), 16'h0003);
		issue(`CMD_TRACE);
		repeat (3) @(posedge ref_clk);
		#1 chk("bg_cmd", 16'(status_q), 16'h0000);
		reg_rd(`ADDR_SP, v);
		chk("bg_sp", v, 16'h0000);
		reg_rd(4'hF, v);
		chk("unmapped", v, 16'h0000);
		$display("test background done");
		enter(16'h1234);
		reg_rd(`ADDR_SP, v);
		chk("entry_sp", v, 16'h0001);
		chk("dbg_gate", 16'({sys_clk_en_q, timer_enable_q}), 16'h0000);
		issue(`CMD_TRACE);
		@(posedge ref_clk);
		#1 chk("busy", 16'(status_q), 16'(`ST_BUSY));
		@(posedge ref_clk);
		#1 chk("step_ip", ip_load_q, 16'h1234);
		chk("step_run", 16'({ip_load_en_q, cpu_run_q}), 16'h0003);
		chk("step_ige", 16'(interrupt_global_enable_q), 16'h0001);
		@(posedge ref_clk);
		cpu_ip <= 16'h1235;
		cpu_ige <= 1'b0;
		cpu_done <= 1'b1;
		@(posedge ref_clk);
		cpu_done <= 1'b0;
		#1 chk("stall", 16'({cpu_run_q, fetch_block_q}), 16'h0001);
		wait_st(`ST_IDLE);
		chk("vector", ip_load_q, `DEBUG_VECTOR);
		chk("ige_off", 16'(interrupt_global_enable_q), 16'h0000);
		reg_rd(`ADDR_IP, v);
		chk("pushed", v, 16'h1235);
		$display("test trace done");
		issue(`CMD_RETURN);
		wait_st(`ST_NONDEBUG);
		chk("ret_ige", 16'(interrupt_global_enable_q), 16'h0001);
		chk("ret_run", 16'({cpu_run_q, timer_enable_q}), 16'h0003);
		chk("brk_sup", 16'(brk_suppress_q), 16'h0001);
		$display("test return done");
		enter(16'h2000);
		reg_wr(`ADDR_BUF, 16'h00A5);
		reg_rd(`ADDR_CTRL, v);
		chk("txc", 16'(v[`CTRL_TXC_BIT]), 16'h0001);
		issue(`CMD_DUMP);
		for (i = 0; i < 433; i++) begin
			reg_wr(`ADDR_BUF, 16'(i % 256));
			xfer();
			v = (i == 0) ? 16'(`PERIPH_WORDS) : 16'(i % 256);
			chk("dump_byte", 16'(dump_byte_q), v);
			v = 16'(i > 0 && (i - 1) / 2 >= `DUMP_PAIR_WORD);
			chk("dump_pair", 16'(dump_word_pair_q), v);
			v = (i < 432) ? 16'(`ST_VALID) : 16'(`ST_IDLE);
			chk("dump_st", 16'(status_q), v);
		end
		reg_rd(`ADDR_CTRL, v);
		chk("txc_clr", 16'(v[`CTRL_TXC_BIT]), 16'h0000);
		$display("test dump done");
		reg_wr(`ADDR_CTRL, 16'h0001);
		#1 chk("stop", 16'(stop_q), 16'h0001);
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("rst_bg", 16'({status_q, stop_q}), 16'h0000);
		$display("test stop reset done");
		test_done();
	end
endmodule

// ---- tb/step_return_chk.sv ----
`timescale 1ns/1ps
`include "dbg_step_defines.vh"

module step_return_chk (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic        cpu_done,
	input wire logic [1:0]  status_q,
	input wire logic [15:0] ip_load_q,
	input wire logic        ip_load_en_q,
	input wire logic        interrupt_global_enable_q,
	input wire logic        cpu_run_q,
	input wire logic        fetch_block_q,
	input wire logic        timer_enable_q
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	AST_BUSY: assert property (
		status_q == `ST_IDLE && cmd_valid && cmd_code == `CMD_TRACE
		|=> status_q == `ST_BUSY) else $error("trace not busy");
	AST_STEP: assert property (
		status_q == `ST_IDLE && cmd_valid && cmd_code == `CMD_TRACE
		|=> ##1 ip_load_en_q && cpu_run_q) else $error("no step load");
	AST_PULSE: assert property (
		ip_load_en_q |=> !ip_load_en_q) else $error("load too long");
	AST_STALL: assert property (
		status_q == `ST_BUSY && cpu_run_q && cpu_done
		|=> !cpu_run_q && fetch_block_q) else $error("no stall");
	AST_FINISH: assert property (
		status_q == `ST_BUSY && cpu_run_q && cpu_done |=> ##1
		status_q == `ST_IDLE && ip_load_q == `DEBUG_VECTOR &&
		!interrupt_global_enable_q) else $error("bad trace end");
	AST_RET: assert property (
		status_q == `ST_IDLE && cmd_valid && cmd_code == `CMD_RETURN
		|=> ##1 status_q == `ST_NONDEBUG) else $error("no return");
	AST_TIMER: assert property (
		status_q == `ST_NONDEBUG [*2] |-> timer_enable_q && cpu_run_q)
		else $error("timers off in background");
	AST_IGNORE: assert property (
		status_q == `ST_NONDEBUG && cmd_valid |=> status_q != `ST_BUSY)
		else $error("command taken in background");
endmodule

bind debug_step_return_control step_return_chk u_chk (
	.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .cpu_done(cpu_done), .status_q(status_q),
	.ip_load_q(ip_load_q), .ip_load_en_q(ip_load_en_q),
	.interrupt_global_enable_q(interrupt_global_enable_q),
	.cpu_run_q(cpu_run_q), .fetch_block_q(fetch_block_q),
	.timer_enable_q(timer_enable_q));
